// File: include/uart_pkg.sv
/*
 * Shared constants and types for the serial port block: register
 * indices and byte addresses, control register layout, interrupt bits,
 * receiver states and divider counts.
 * Assumes a 32-bit APB with 12-bit byte addresses; each register
 * takes one aligned word at four times its index.
 */
`default_nettype none

package uart_pkg;

    // Address width of the register bus
    localparam int ADDR_W = 12;

    // Register indices; byte address is four times the index
    localparam logic [9:0] IDX_CONTROL = 10'h098;
    localparam logic [9:0] IDX_DATA = 10'h099;
    localparam logic [9:0] IDX_IRQ_STATUS = 10'h09A;
    localparam logic [9:0] IDX_IRQ_MASK = 10'h09B;
    localparam logic [9:0] IDX_BAUD_SEL = 10'h09C;
    localparam logic [11:0] ADDR_CONTROL = {IDX_CONTROL, 2'b00};
    localparam logic [11:0] ADDR_DATA = {IDX_DATA, 2'b00};
    localparam logic [11:0] ADDR_IRQ_STATUS = {IDX_IRQ_STATUS, 2'b00};
    localparam logic [11:0] ADDR_IRQ_MASK = {IDX_IRQ_MASK, 2'b00};
    localparam logic [11:0] ADDR_BAUD_SEL = {IDX_BAUD_SEL, 2'b00};

    // Reset values
    localparam logic [7:0] CONTROL_RST = 8'h00;
    localparam logic [7:0] DATA_RST = 8'h00;

    // Interrupt status and mask bits
    localparam int IRQ_RX = 0;
    localparam int IRQ_TX = 1;
    localparam int IRQ_LOST = 2;
    localparam int IRQ_W = 3;

    // Baud select bits: set picks the second timer
    localparam int BAUD_TX_T2 = 0;
    localparam int BAUD_RX_T2 = 1;

    // Oversampling and divider counts
    localparam int OS_PER_BIT = 16;
    localparam logic [3:0] OS_MID = 4'h7;
    localparam logic [3:0] OS_LAST = 4'hF;
    localparam int M0_HALF = 6;
    localparam int M2_OS_DIV = 2;
    localparam logic [3:0] M0_BITS = 4'h8;

    // Operating modes
    typedef enum logic [1:0] {
        MODE_SHIFT = 2'b00,
        MODE_8BIT = 2'b01,
        MODE_9FIX = 2'b10,
        MODE_9VAR = 2'b11
    } mode_t;

    // Control register layout, bit 7 first
    typedef struct packed {
        mode_t mode;
        logic multiprocessor_enable;
        logic receive_enable;
        logic transmit_ninth_bit;
        logic receive_ninth_bit;
        logic transmit_done_flag;
        logic receive_done_flag;
    } control_t;

    // Asynchronous receiver states
    typedef enum logic [1:0] {
        RX_IDLE = 2'b00,
        RX_START = 2'b01,
        RX_DATA = 2'b10,
        RX_STOP = 2'b11
    } rx_state_t;

endpackage

`default_nettype wire

// File: hw/pulse_divider.sv
/*
 * Pulse divider: emits one tick for every DIV enable pulses.
 * Assumes enable pulses are synchronous to pclk; clr restarts the count.
 */
`timescale 1ns/1ps
`default_nettype none

module pulse_divider #(
    parameter int DIV = 16
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Control
    input wire logic clr,
    input wire logic en,
    // Result
    output logic tick
);

    localparam int W = (DIV > 1) ? $clog2(DIV) : 1;
    localparam logic [W-1:0] LAST = W'(DIV - 1);

    // A zero divide has no meaning
    if (DIV < 1)
    begin : g_bad_div
        $error("pulse_divider: DIV must be at least 1");
    end

    // Count of enable pulses seen
    logic [W-1:0] cnt;

    assign tick = en && (cnt == LAST);

    // Restart on clear so the first tick is a full period away
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            cnt <= '0;
        else if (clr || tick)
            cnt <= '0;
        else if (en)
            cnt <= cnt + 1'b1;
    end

endmodule // pulse_divider

`default_nettype wire

// File: hw/uart_serial_port.sv
/*
 * Serial port: shift register mode, 8-bit and 9-bit asynchronous modes,
 * control and data buffer registers, sticky interrupt status on APB.
 * Assumes timer overflow inputs are one-cycle pulses and all pins are
 * synchronous to pclk; the RxD pin buffer is resolved outside.
 */
`timescale 1ns/1ps
`default_nettype none

module uart_serial_port #(
    parameter int MODE0_HALF = uart_pkg::M0_HALF,
    parameter int MODE2_OS_DIV = uart_pkg::M2_OS_DIV
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [uart_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Timer overflow pulses
    input wire logic timer1_overflow,
    input wire logic timer2_overflow,
    // Serial pins
    input wire logic rxd_in,
    output logic rxd_out,
    output logic rxd_oe,
    output logic txd,
    // Interrupt
    output logic irq
);

    if (MODE0_HALF < 1 || MODE2_OS_DIV < 1)
    begin : g_bad_param
        $error("uart_serial_port: dividers must be at least 1");
    end

    // Registers
    uart_pkg::control_t control;        // Mode, enables, flags
    logic [7:0] rx_buffer;              // Receive side of data buffer
    logic [uart_pkg::IRQ_W-1:0] irq_status;
    logic [uart_pkg::IRQ_W-1:0] irq_mask;
    logic [1:0] baud_sel;               // Timer choice per direction

    // APB decode
    wire apb_access = psel && penable;
    wire wr = apb_access && pwrite;
    wire hit_control = (paddr == uart_pkg::ADDR_CONTROL);
    wire hit_data = (paddr == uart_pkg::ADDR_DATA);
    wire hit_status = (paddr == uart_pkg::ADDR_IRQ_STATUS);
    wire hit_mask = (paddr == uart_pkg::ADDR_IRQ_MASK);
    wire hit_baud = (paddr == uart_pkg::ADDR_BAUD_SEL);
    wire hit_any = hit_control | hit_data | hit_status | hit_mask
        | hit_baud;
    wire wr_control = wr && hit_control;
    wire wr_data = wr && hit_data;      // Loads transmitter
    wire wr_status = wr && hit_status;

    // Mode decode
    wire mode0 = (control.mode == uart_pkg::MODE_SHIFT);
    wire nine = control.mode[1];

    // Zero wait states; unmapped addresses answer with an error
    assign pready = 1'b1;
    assign pslverr = apb_access && !hit_any;
    assign prdata = hit_control ? {24'h00_0000, control}
        : hit_data ? {24'h00_0000, rx_buffer}   // Separate register
        : hit_status ? {29'h0000_0000, irq_status}
        : hit_mask ? {29'h0000_0000, irq_mask}
        : hit_baud ? {30'h0000_0000, baud_sel}
        : 32'h0000_0000;

    // Oversample ticks; mode 2 runs from a fixed core divider
    logic fixed_os;
    wire tx_os = (control.mode == uart_pkg::MODE_9FIX) ? fixed_os
        : baud_sel[uart_pkg::BAUD_TX_T2] ? timer2_overflow
        : timer1_overflow;
    wire rx_os = (control.mode == uart_pkg::MODE_9FIX) ? fixed_os
        : baud_sel[uart_pkg::BAUD_RX_T2] ? timer2_overflow
        : timer1_overflow;

    // Asynchronous transmitter
    logic tx_busy;
    logic [10:0] tx_sr;                 // Start, data, ninth, stop
    logic [3:0] tx_cnt;                 // Bits already sent
    logic tx_bit;                       // One bit time elapsed
    wire tx_load = wr_data && !mode0 && !tx_busy;
    wire [3:0] tx_frame = nine ? 4'hB : 4'hA;
    wire tx_stop_begin = tx_bit && (tx_cnt == tx_frame - 4'h2);
    wire tx_end = tx_bit && (tx_cnt == tx_frame - 4'h1);

    // Sixteen oversample ticks make one transmitted bit
    pulse_divider #(.DIV(uart_pkg::OS_PER_BIT)) u_tx_bit (
        .pclk(pclk),
        .presetn(presetn),
        .clr(!tx_busy),
        .en(tx_os),
        .tick(tx_bit)
    );

    // Mode 2 oversample clock from the core clock
    pulse_divider #(.DIV(MODE2_OS_DIV)) u_fixed_os (
        .pclk(pclk),
        .presetn(presetn),
        .clr(1'b0),
        .en(1'b1),
        .tick(fixed_os)
    );

    // Frame shift register; writes while busy are ignored
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tx_busy <= 1'b0;
            tx_sr <= 11'h7FF;
            tx_cnt <= 4'h0;
        end
        else if (tx_load)
        begin
            // Ninth slot: stop bit in mode 1, software bit otherwise
            tx_sr <= {1'b1, nine ? control.transmit_ninth_bit : 1'b1,
                pwdata[7:0], 1'b0};
            tx_busy <= 1'b1;
            tx_cnt <= 4'h0;
        end
        else if (tx_bit)
        begin
            tx_sr <= {1'b1, tx_sr[10:1]};               // LSB first
            tx_cnt <= tx_cnt + 4'h1;
            if (tx_end)
                tx_busy <= 1'b0;
        end
    end

    // Mode 0 shift engine
    logic m0_busy;
    logic m0_rx;                        // Direction of current transfer
    logic m0_phase;                     // Clock low, then high
    logic [7:0] m0_sr;
    logic [3:0] m0_cnt;
    logic m0_half;
    wire m0_tx_load = wr_data && mode0 && !m0_busy;
    wire m0_rx_load = mode0 && !m0_busy && !wr_data
        && control.receive_enable
        && !control.receive_done_flag;
    localparam logic [3:0] M0_LAST = uart_pkg::M0_BITS - 4'h1;
    wire m0_done = m0_half && m0_phase && (m0_cnt == M0_LAST);

    pulse_divider #(.DIV(MODE0_HALF)) u_m0_half (
        .pclk(pclk),
        .presetn(presetn),
        .clr(!m0_busy),
        .en(1'b1),
        .tick(m0_half)
    );

    // Sample on the rising clock edge, shift out on the falling one
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            m0_busy <= 1'b0;
            m0_rx <= 1'b0;
            m0_phase <= 1'b0;
            m0_sr <= 8'h00;
            m0_cnt <= 4'h0;
        end
        else if (m0_tx_load || m0_rx_load)
        begin
            m0_busy <= 1'b1;
            m0_rx <= m0_rx_load;
            m0_phase <= 1'b0;
            m0_sr <= m0_tx_load ? pwdata[7:0] : 8'h00;
            m0_cnt <= 4'h0;
        end
        else if (m0_half)
        begin
            m0_phase <= !m0_phase;
            if (!m0_phase && m0_rx)
                m0_sr <= {rxd_in, m0_sr[7:1]};
            if (m0_phase)
            begin
                if (!m0_rx)
                    m0_sr <= {1'b0, m0_sr[7:1]};        // LSB first
                m0_cnt <= m0_cnt + 4'h1;
                if (m0_done)
                    m0_busy <= 1'b0;
            end
        end
    end

    // Asynchronous receiver
    uart_pkg::rx_state_t rx_state;
    uart_pkg::rx_state_t next_rx_state;
    logic rx_prev;                      // Pin level at last oversample
    logic [3:0] os_cnt;
    logic [3:0] rx_cnt;
    logic [8:0] rx_sr;
    wire [3:0] rx_bits = nine ? 4'h9 : 4'h8;
    wire rx_fall = rx_os && rx_prev && !rxd_in;
    wire rx_centre = rx_os && (os_cnt == uart_pkg::OS_LAST);
    wire start_mid = rx_os && (os_cnt == uart_pkg::OS_MID);
    wire rx_finish = (rx_state == uart_pkg::RX_STOP) && rx_centre;
    wire [7:0] rx_byte = nine ? rx_sr[7:0] : rx_sr[8:1];
    // Stop bit qualifies mode 1, ninth bit the 9-bit modes
    wire rx_qual = nine ? rx_sr[8] : rxd_in;
    wire rx_accept = rx_finish && !mode0
        && (!control.multiprocessor_enable || rx_qual);
    // Unread byte overwritten by the new one
    wire rx_lost = rx_accept && control.receive_done_flag;

    // Next state of the asynchronous receiver
    always_comb
    begin
        next_rx_state = rx_state;
        unique case (rx_state)
            uart_pkg::RX_IDLE:
                if (!mode0 && control.receive_enable && rx_fall)
                    next_rx_state = uart_pkg::RX_START;
            uart_pkg::RX_START:
                if (start_mid)
                    next_rx_state = rxd_in ? uart_pkg::RX_IDLE
                        : uart_pkg::RX_DATA;
            uart_pkg::RX_DATA:
                if (rx_centre && rx_cnt == rx_bits - 4'h1)
                    next_rx_state = uart_pkg::RX_STOP;
            uart_pkg::RX_STOP:
                if (rx_centre)
                    next_rx_state = uart_pkg::RX_IDLE;
        endcase
    end

    // Sixteen oversamples per bit; after the start check each
    // count of sixteen lands on a bit centre
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rx_state <= uart_pkg::RX_IDLE;
            rx_prev <= 1'b1;
            os_cnt <= 4'h0;
            rx_cnt <= 4'h0;
            rx_sr <= 9'h000;
        end
        else
        begin
            rx_state <= next_rx_state;
            if (rx_os)
                rx_prev <= rxd_in;
            if (rx_state == uart_pkg::RX_IDLE || start_mid
                && rx_state == uart_pkg::RX_START)
                os_cnt <= 4'h0;
            else if (rx_os)
                os_cnt <= os_cnt + 4'h1;
            if (rx_state != uart_pkg::RX_DATA)
                rx_cnt <= 4'h0;
            else if (rx_centre)
            begin
                rx_sr <= {rxd_in, rx_sr[8:1]};
                rx_cnt <= rx_cnt + 4'h1;
            end
        end
    end

    // Flags and registers
    wire tx_flag_set = tx_stop_begin || (m0_done && !m0_rx);
    wire rx_flag_set = rx_accept || (m0_done && m0_rx);
    wire [uart_pkg::IRQ_W-1:0] irq_event = {rx_lost, tx_flag_set,
        rx_flag_set};
    wire [uart_pkg::IRQ_W-1:0] irq_clear = wr_status
        ? pwdata[uart_pkg::IRQ_W-1:0] : '0;
    wire [uart_pkg::IRQ_W-1:0] next_irq_status =
        (irq_status & ~irq_clear) | irq_event;           // Set wins
    wire [7:0] w = pwdata[7:0];
    // Hardware set wins over a software write of zero
    wire next_tx_flag = tx_flag_set
        || (wr_control ? w[1] : control.transmit_done_flag);
    wire next_rx_flag = rx_flag_set
        || (wr_control ? w[0] : control.receive_done_flag);
    wire next_rx_ninth = rx_accept ? (nine ? rx_sr[8] : rxd_in)
        : wr_control ? w[2] : control.receive_ninth_bit;

    // Control register: software fields plus hardware-set flags
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            control <= uart_pkg::control_t'(uart_pkg::CONTROL_RST);
        else
        begin
            if (wr_control)
            begin
                control.mode <= uart_pkg::mode_t'(w[7:6]);
                control.multiprocessor_enable <= w[5];
                control.receive_enable <= w[4];
                control.transmit_ninth_bit <= w[3];
            end
            control.receive_ninth_bit <= next_rx_ninth;
            control.transmit_done_flag <= next_tx_flag;
            control.receive_done_flag <= next_rx_flag;
        end
    end

    // Receive buffer and own registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rx_buffer <= uart_pkg::DATA_RST;
            irq_status <= '0;
            irq_mask <= '0;
            baud_sel <= 2'b00;
        end
        else
        begin
            if (rx_accept)
                rx_buffer <= rx_byte;
            else if (m0_done && m0_rx)
                rx_buffer <= m0_sr;
            irq_status <= next_irq_status;
            if (wr && hit_mask)
                irq_mask <= pwdata[uart_pkg::IRQ_W-1:0];
            if (wr && hit_baud)
                baud_sel <= pwdata[1:0];
        end
    end

    // Pins: mode 0 drives transmit data on RxD and the shift clock on TxD
    assign rxd_oe = mode0 && m0_busy && !m0_rx;
    assign rxd_out = rxd_oe && m0_sr[0];
    assign txd = mode0 ? (!m0_busy || m0_phase)
        : (!tx_busy || tx_sr[0]);
    assign irq = |(irq_status & irq_mask);

    // Assertions
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    a_rx_enable_gate: assert property ((rx_state == uart_pkg::RX_IDLE
        && !control.receive_enable) |=> rx_state == uart_pkg::RX_IDLE)
        else $error("receiver started while disabled");
    a_tx_ninth_load: assert property ((tx_load && nine)
        |=> tx_sr[9] == $past(control.transmit_ninth_bit))
        else $error("ninth bit not loaded");
    a_rx_ninth_stop: assert property ((rx_accept && !nine)
        |=> control.receive_ninth_bit == $past(rxd_in))
        else $error("stop bit not stored");
    a_tx_flag_sticky: assert property ((control.transmit_done_flag
        && !wr_control) |=> control.transmit_done_flag)
        else $error("transmit flag dropped");
    a_rx_flag_sticky: assert property ((control.receive_done_flag
        && !wr_control) |=> control.receive_done_flag)
        else $error("receive flag dropped");
    a_rxd_drive: assert property (!mode0 |-> !rxd_oe)
        else $error("RxD driven outside mode 0");
    a_shift_clock: assert property ((mode0 && m0_busy && m0_half
        && !m0_done && !wr_control) |=> txd != $past(txd))
        else $error("shift clock did not toggle");
    a_m0_tx_start: assert property (m0_tx_load
        |=> m0_busy && rxd_oe && !txd)
        else $error("mode 0 transmit did not start");
    a_m0_rx_gate: assert property ($rose(m0_busy) && !$past(wr_data)
        |-> $past(control.receive_enable
        && !control.receive_done_flag))
        else $error("mode 0 receive started wrongly");
    a_start_bit: assert property (tx_load
        |=> (!txd && tx_busy) [*8])
        else $error("start bit too short");
    a_stop_gate: assert property ((rx_finish && !nine && !rxd_in
        && control.multiprocessor_enable && !control.receive_done_flag)
        |=> !control.receive_done_flag)
        else $error("flag set without valid stop bit");

    c_tx_frame: cover property (tx_end);
    c_rx_frame: cover property (rx_accept);
    c_m0_receive: cover property (m0_done && m0_rx);
    c_overrun: cover property (rx_lost);

endmodule // uart_serial_port

`default_nettype wire

// File: verif/serial_node.sv
/*
 * Remote serial node: drives RxD with asynchronous frames or acts as
 * an external shift register, and captures frames seen on TxD.
 * Assumes pclk is the bench clock and both lines idle high.
 */
`timescale 1ns/1ps
`default_nettype none

module serial_node (
    // Clock
    input wire logic pclk,
    // Serial lines
    input wire logic txd,
    output logic rxd_line
);
    logic [15:0] sr = 16'hFFFF; // Shift data, ones keep the line idle
    logic txd_q = 1'b1; // Shift clock one cycle back

    initial rxd_line = 1'b1;

    // Shift register mode: next bit after each falling shift clock
    always @(posedge pclk)
    begin
        txd_q <= txd;
        if (txd_q && !txd)
        begin
            rxd_line <= sr[0];
            sr <= {1'b1, sr[15:1]};
        end
    end

    // Preload a byte for the device to clock in
    task load_shift(input logic [7:0] v);
        sr = {8'hFF, v};
    endtask

    // Frame out LSB first, then back to the idle level
    task send_bits(input int cyc, input logic [10:0] b, input int n);
        for (int i = 0; i <= n; i++)
        begin
            rxd_line <= (i < n) ? b[i] : 1'b1;
            repeat (cyc) @(posedge pclk);
        end
    endtask

    // Capture n bits at mid-bit; a missing frame leaves all ones
    task get_frame(input int cyc, input int n, output logic [10:0] b);
        int k;
        b = '1;
        k = 0;
        while (txd !== 1'b0 && k < 5000)
        begin
            @(posedge pclk);
            k++;
        end
        repeat (cyc / 2) @(posedge pclk);
        for (int i = 0; i < n && k < 5000; i++)
        begin
            b[i] = txd;
            repeat (cyc) @(posedge pclk);
        end
    endtask
endmodule // serial_node

`default_nettype wire

// File: verif/testbench.sv
/*
 * Self-checking bench for the serial port: APB master, timer pulses,
 * frame model with queues, compared at every result.
 * Assumes zero or more wait states and the serial_node partner.
 */
`timescale 1ns/1ps
`default_nettype none

module testbench;
    localparam logic [11:0] CTL = uart_pkg::ADDR_CONTROL;
    localparam logic [11:0] DAT = uart_pkg::ADDR_DATA;
    localparam logic [11:0] STA = uart_pkg::ADDR_IRQ_STATUS;
    localparam logic [11:0] MSK = uart_pkg::ADDR_IRQ_MASK;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic timer1_overflow, timer2_overflow, irq;
    logic rxd_in, rxd_out, rxd_oe, txd, node_rxd;
    logic [10:0] fb; // Captured frame
    logic [7:0] d;
    logic [7:0] exp_rx[$]; // Bytes expected in the receive buffer
    logic [31:0] seed = 32'h0000_8A23;
    int failures = 0;
    int check_count = 0;
    int cyc = 0;
    int bit_n; // Mode 0 bits seen
    logic txd_last; // Shift clock at the last edge

    // Open RxD: device drives only while its enable is up
    assign rxd_in = rxd_oe ? rxd_out : node_rxd;

    uart_serial_port u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .timer1_overflow(timer1_overflow),
        .timer2_overflow(timer2_overflow), .rxd_in(rxd_in),
        .rxd_out(rxd_out), .rxd_oe(rxd_oe), .txd(txd), .irq(irq));
    serial_node u_node (.pclk(pclk), .txd(txd), .rxd_line(node_rxd));

    initial
    begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    // Timer pulses: bit of 64 cycles on timer1, 48 on timer2
    always @(posedge pclk)
    begin
        cyc <= cyc + 1;
        timer1_overflow <= (cyc % 4 == 0);
        timer2_overflow <= (cyc % 3 == 0);
    end

    function logic [7:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction

    // Frame model: start 0, data LSB first, then bits 9 and 10
    function logic [10:0] mk(input logic [7:0] v, input logic b9,
        input logic b10);
        return {b10, b9, v, 1'b0};
    endfunction

    task check_val(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            failures++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One APB transfer; holds until pready, bounded
    task apb(input logic w, input logic [11:0] a, input logic [7:0] v);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, v};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        er = pslverr;
        if (n >= 50)
        begin
            failures++;
            $display("Error %0t: bus timeout", $time);
            complete_run();
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task rd_chk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 8'h00);
        check_val(rd, exp);
    endtask

    task irq_chk(input logic e);
        #1;
        check_val({31'h0, irq}, {31'h0, e});
    endtask

    // Poll control until a flag rises, bounded
    task wait_flag(input logic [7:0] m);
        int k;
        k = 0;
        do
        begin
            apb(1'b0, CTL, 8'h00);
            k++;
        end while ((rd[7:0] & m) == 8'h00 && k < 100);
        if ((rd[7:0] & m) == 8'h00)
        begin
            failures++;
            $display("Error %0t: flag wait timed out", $time);
            complete_run();
        end
    endtask

    task rx_one(input logic b9, input int n);
        d = xs();
        exp_rx.push_back(d);
        u_node.send_bits(48, mk(d, b9, 1'b1), n);
    endtask

    task complete_run();
        $display("Checks %0d, mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // Main sequence
    initial
    begin
        presetn = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {timer1_overflow, timer2_overflow} = 2'b00;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        rd_chk(CTL, 32'h0000_0000);
        rd_chk(DAT, 32'h0000_0000);
        apb(1'b0, 12'h000, 8'h00);
        check_val({31'h0, er}, 32'h0000_0001);
        apb(1'b1, uart_pkg::ADDR_BAUD_SEL, 8'h02);
        apb(1'b1, MSK, 8'h07);
        // Mode 1 transmit, interrupt raised, masked and cleared
        apb(1'b1, CTL, 8'h40);
        d = xs();
        fork
            u_node.get_frame(64, 10, fb);
            apb(1'b1, DAT, d);
        join
        check_val({21'h0, fb}, {21'h0, mk(d, 1'b1, 1'b1)});
        rd_chk(CTL, 32'h0000_0042);
        irq_chk(1'b1);
        apb(1'b1, MSK, 8'h00);
        irq_chk(1'b0);
        apb(1'b1, MSK, 8'h07);
        irq_chk(1'b1);
        apb(1'b1, STA, 8'h02);
        irq_chk(1'b0);
        // Receiver off, then on, then an overrun
        apb(1'b1, CTL, 8'h40);
        rx_one(1'b1, 10);
        void'(exp_rx.pop_back());
        rd_chk(CTL, 32'h0000_0040);
        apb(1'b1, CTL, 8'h50);
        rx_one(1'b1, 10);
        rd_chk(CTL, 32'h0000_0055);
        rd_chk(DAT, {24'h0, exp_rx.pop_front()});
        rx_one(1'b1, 10);
        rx_one(1'b1, 10);
        void'(exp_rx.pop_front());
        rd_chk(DAT, {24'h0, exp_rx.pop_front()});
        rd_chk(STA, 32'h0000_0005);
        apb(1'b1, STA, 8'h07);
        // Short low pulse: the start check must reject it
        apb(1'b1, CTL, 8'h50);
        u_node.send_bits(12, 11'h7FE, 1);
        repeat (600) @(posedge pclk);
        rd_chk(CTL, 32'h0000_0050);
        // Low stop bit: kept plainly, dropped in multiprocessor use
        rx_one(1'b0, 10);
        rd_chk(CTL, 32'h0000_0051);
        rd_chk(DAT, {24'h0, exp_rx.pop_front()});
        apb(1'b1, CTL, 8'h70);
        rx_one(1'b0, 10);
        void'(exp_rx.pop_back());
        rd_chk(CTL, 32'h0000_0070);
        rx_one(1'b1, 10);
        rd_chk(CTL, 32'h0000_0075);
        rd_chk(DAT, {24'h0, exp_rx.pop_front()});
        // Nine-bit fixed rate transmit, ninth bit clear
        apb(1'b1, CTL, 8'h80);
        d = xs();
        fork
            u_node.get_frame(32, 11, fb);
            apb(1'b1, DAT, d);
        join
        check_val({21'h0, fb}, {21'h0, mk(d, 1'b0, 1'b1)});
        // Nine-bit variable mode both ways
        apb(1'b1, CTL, 8'hC8);
        d = xs();
        fork
            u_node.get_frame(64, 11, fb);
            apb(1'b1, DAT, d);
        join
        check_val({21'h0, fb}, {21'h0, mk(d, 1'b1, 1'b1)});
        apb(1'b1, CTL, 8'hD8);
        rx_one(1'b0, 11);
        rd_chk(CTL, 32'h0000_00D9);
        rd_chk(DAT, {24'h0, exp_rx.pop_front()});
        // Mode 0 transmit: sample data at each rising shift clock
        apb(1'b1, CTL, 8'h00);
        d = xs();
        apb(1'b1, DAT, d);
        fb = '0;
        bit_n = 0;
        txd_last = 1'b1;
        for (int k = 0; bit_n < 8 && k < 400; k++)
        begin
            @(posedge pclk);
            if (txd && !txd_last && rxd_oe)
            begin
                fb[bit_n] = rxd_out;
                bit_n++;
            end
            txd_last = txd;
        end
        check_val({24'h0, fb[7:0]}, {24'h0, d});
        wait_flag(8'h02);
        rd_chk(CTL, 32'h0000_0002);
        // Mode 0 receive from the external shift register
        d = xs();
        u_node.load_shift(d);
        apb(1'b1, CTL, 8'h10);
        wait_flag(8'h01);
        rd_chk(CTL, 32'h0000_0011);
        rd_chk(DAT, {24'h0, d});
        complete_run();
    end

    // Hang guard
    initial
    begin
        #900_000;
        failures++;
        complete_run();
    end
endmodule // testbench

`default_nettype wire
